// >>> src/tdp_regs.vh
// Constants shared by the trace detector processor.
`ifndef TDP_REGS_VH
`define TDP_REGS_VH

// Trace geometry and data widths.
`define TDP_PIXELS          9'h12D
`define TDP_PIX_W           9
`define TDP_LVL_W           16
`define TDP_CNT_W           10
`define TDP_SQ_W            48
`define TDP_N_W             24

// Trace mode codes.
`define TDP_MODE_OVERWRITE  3'h0
`define TDP_MODE_SMOOTH     3'h1
`define TDP_MODE_PEAK       3'h2
`define TDP_MODE_FLOOR      3'h3
`define TDP_MODE_FROZEN     3'h4

// Detector codes.
`define TDP_DET_BIPOLAR     3'h0
`define TDP_DET_UPPER       3'h1
`define TDP_DET_LOWER       3'h2
`define TDP_DET_SINGLE      3'h3
`define TDP_DET_POWER       3'h4

// Smoothing depth limits and reset value.
`define TDP_DEPTH_RESET     10'h00A
`define TDP_DEPTH_MIN       10'h002
`define TDP_DEPTH_MAX       10'h3E7

// Reset values of the coupling flag and the level outputs.
`define TDP_FOLLOW_RESET    1'b1
`define TDP_LVL_RESET       16'h0000

`endif

// >>> src/tdp_core.v
// Trace detector processor: per-pixel detection and trace combination.
`timescale 1ns/100ps
`include "tdp_regs.vh"

module tdp_core
(
  // Clock and reset
  input  wire                    clk,
  input  wire                    reset,
  // Front end video stream
  input  wire                    in_valid,
  input  wire [`TDP_LVL_W-1:0]   in_level,
  input  wire                    in_pixel_end,
  input  wire                    in_sweep_end,
  // Settings
  input  wire [2:0]              trace_mode_sel,
  input  wire [`TDP_CNT_W-1:0]   smoothing_depth,
  input  wire                    one_shot_sweep,
  input  wire                    setting_change,
  input  wire [2:0]              detector_manual,
  input  wire                    detector_manual_wr,
  input  wire                    follows_wr,
  input  wire                    follows_value,
  // Display side
  output reg                     out_valid,
  output reg  [`TDP_PIX_W-1:0]   out_pixel,
  output reg  [`TDP_LVL_W-1:0]   out_hi,
  output reg  [`TDP_LVL_W-1:0]   out_lo,
  // Status
  output reg  [2:0]              active_detector,
  output reg                     detector_follows_mode,
  output reg  [2:0]              reported_mode,
  output wire                    view_freeze,
  output wire                    measure_abort,
  output wire                    sweep_halted,
  output reg  [`TDP_CNT_W-1:0]   traces_collected
);

  localparam [2:0] ST_RUN    = 3'b001;
  localparam [2:0] ST_HALT   = 3'b010;
  localparam [2:0] ST_FROZEN = 3'b100;

  reg  [2:0]             state;
  reg  [`TDP_PIX_W-1:0]  pix_idx;
  reg  [`TDP_LVL_W-1:0]  acc_hi;
  reg  [`TDP_LVL_W-1:0]  acc_lo;
  reg  [`TDP_LVL_W-1:0]  acc_first;
  reg  [`TDP_SQ_W-1:0]   acc_sq;
  reg  [`TDP_N_W-1:0]    acc_n;
  reg  [`TDP_LVL_W-1:0]  mem_hi [0:`TDP_PIXELS-1];
  reg  [`TDP_LVL_W-1:0]  mem_lo [0:`TDP_PIXELS-1];

  // Maps a trace mode onto its coupled detector.
  function [2:0] tdp_map_det;
    input [2:0] mode;
    begin
      case (mode)
        `TDP_MODE_SMOOTH: tdp_map_det = `TDP_DET_SINGLE;
        `TDP_MODE_PEAK:   tdp_map_det = `TDP_DET_UPPER;
        `TDP_MODE_FLOOR:  tdp_map_det = `TDP_DET_LOWER;
        default:          tdp_map_det = `TDP_DET_BIPOLAR;
      endcase
    end
  endfunction

  // Bitwise integer square root, rounded down.
  function [15:0] tdp_isqrt;
    input [31:0] v;
    reg   [15:0] root;
    reg   [15:0] trial;
    integer      i;
    begin
      root = 16'h0000;
      for (i = 15; i >= 0; i = i - 1)
      begin
        trial = root | (16'h0001 << i);
        if (({16'h0000, trial} * {16'h0000, trial}) <= v)
          root = trial;
      end
      tdp_isqrt = root;
    end
  endfunction

  // Running mean step: old + (new - old) / n, with the quotient truncated toward zero.
  function [15:0] tdp_avg;
    input [15:0] old_v;
    input [15:0] new_v;
    input [9:0]  n;
    reg signed [17:0] diff;
    reg signed [17:0] step;
    reg signed [17:0] sum;
    begin
      diff = $signed({2'b00, new_v}) - $signed({2'b00, old_v});
      step = diff / $signed({8'h00, n});
      sum = $signed({2'b00, old_v}) + step;
      tdp_avg = sum[15:0];
    end
  endfunction

  // Effective depth clamped to the legal range.
  wire [`TDP_CNT_W-1:0] depth = (smoothing_depth < `TDP_DEPTH_MIN) ? `TDP_DEPTH_MIN :
                                (smoothing_depth > `TDP_DEPTH_MAX) ? `TDP_DEPTH_MAX :
                                smoothing_depth;

  wire mode_is_frozen = (trace_mode_sel == `TDP_MODE_FROZEN);
  wire mode_changed   = !mode_is_frozen && (trace_mode_sel != reported_mode);
  wire restart        = setting_change || mode_changed;
  wire running        = (state == ST_RUN) && !mode_is_frozen;
  wire take           = running && in_valid;
  wire pix_ok         = (pix_idx < `TDP_PIXELS);
  wire pix_done       = take && in_pixel_end && pix_ok;

  assign view_freeze   = (state == ST_FROZEN);
  assign measure_abort = (state == ST_FROZEN);
  assign sweep_halted  = (state == ST_HALT);

  // Slice statistics including the sample of this cycle.
  wire                  acc_empty = (acc_n == {`TDP_N_W{1'b0}});
  wire [`TDP_LVL_W-1:0] c_hi      = (acc_empty || in_level > acc_hi) ? in_level : acc_hi;
  wire [`TDP_LVL_W-1:0] c_lo      = (acc_empty || in_level < acc_lo) ? in_level : acc_lo;
  wire [`TDP_LVL_W-1:0] c_first   = acc_empty ? in_level : acc_first;
  wire [31:0]           c_sqr     = in_level * in_level;
  wire [`TDP_SQ_W-1:0]  c_sq      = acc_sq + {16'h0000, c_sqr};
  wire [`TDP_N_W-1:0]   c_n       = acc_n + 24'h00_0001;
  wire [`TDP_SQ_W-1:0]  c_mean    = c_sq / {24'h00_0000, c_n};
  wire [`TDP_LVL_W-1:0] c_rms     = tdp_isqrt(c_mean[31:0]);

  reg [`TDP_LVL_W-1:0] det_hi;
  reg [`TDP_LVL_W-1:0] det_lo;

  // Dual extreme keeps both bounds; every other detector shows one value on both outputs.
  always @*
  begin
    case (active_detector)
      `TDP_DET_UPPER:  det_hi = c_hi;
      `TDP_DET_LOWER:  det_hi = c_lo;
      `TDP_DET_SINGLE: det_hi = c_first;
      `TDP_DET_POWER:  det_hi = c_rms;
      default:         det_hi = c_hi;
    endcase
    det_lo = ((active_detector >= `TDP_DET_UPPER) && (active_detector <= `TDP_DET_POWER)) ?
             det_hi : c_lo;
  end

  // Combination with the stored trace.
  wire [`TDP_LVL_W-1:0] old_hi     = mem_hi[pix_idx];
  wire [`TDP_LVL_W-1:0] old_lo     = mem_lo[pix_idx];
  wire                  first_tr   = (traces_collected == {`TDP_CNT_W{1'b0}});
  wire [`TDP_CNT_W-1:0] avg_n      = (traces_collected >= depth) ? depth :
                                     traces_collected + 10'h001;

  reg [`TDP_LVL_W-1:0] next_hi;
  reg [`TDP_LVL_W-1:0] next_lo;

  always @*
  begin
    next_hi = det_hi;
    next_lo = det_lo;
    case (reported_mode)
      `TDP_MODE_SMOOTH:
      begin
        next_hi = first_tr ? det_hi : tdp_avg(old_hi, det_hi, avg_n);
        next_lo = first_tr ? det_lo : tdp_avg(old_lo, det_lo, avg_n);
      end
      `TDP_MODE_PEAK:
      begin
        if (!first_tr)
        begin
          next_hi = (det_hi > old_hi) ? det_hi : old_hi;
          next_lo = (det_lo > old_lo) ? det_lo : old_lo;
        end
      end
      `TDP_MODE_FLOOR:
      begin
        if (!first_tr)
        begin
          next_hi = (det_hi < old_hi) ? det_hi : old_hi;
          next_lo = (det_lo < old_lo) ? det_lo : old_lo;
        end
      end
      default:
      begin
        next_hi = det_hi;
        next_lo = det_lo;
      end
    endcase
  end

  // The trace store needs no reset: the first trace after a restart replaces it.
  always @(posedge clk)
  begin
    if (pix_done)
    begin
      mem_hi[pix_idx] <= next_hi;
      mem_lo[pix_idx] <= next_lo;
    end
  end

  // Slice accumulators and pixel position.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pix_idx   <= 9'h000;
      acc_hi    <= `TDP_LVL_RESET;
      acc_lo    <= `TDP_LVL_RESET;
      acc_first <= `TDP_LVL_RESET;
      acc_sq    <= 48'h0000_0000_0000;
      acc_n     <= 24'h00_0000;
    end
    else if (!running || restart)
    begin
      pix_idx <= 9'h000;
      acc_n   <= 24'h00_0000;
      acc_sq  <= 48'h0000_0000_0000;
    end
    else if (take)
    begin
      if (in_pixel_end || in_sweep_end)
      begin
        acc_n  <= 24'h00_0000;
        acc_sq <= 48'h0000_0000_0000;
      end
      else
      begin
        acc_hi    <= c_hi;
        acc_lo    <= c_lo;
        acc_first <= c_first;
        acc_sq    <= c_sq;
        acc_n     <= c_n;
      end
      if (in_sweep_end)
        pix_idx <= 9'h000;
      else if (in_pixel_end && pix_ok)
        pix_idx <= pix_idx + 9'h001;
    end
  end

  // Display output register.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      out_valid <= 1'b0;
      out_pixel <= 9'h000;
      out_hi    <= `TDP_LVL_RESET;
      out_lo    <= `TDP_LVL_RESET;
    end
    else
    begin
      out_valid <= pix_done;
      if (pix_done)
      begin
        out_pixel <= pix_idx;
        out_hi    <= next_hi;
        out_lo    <= next_lo;
      end
    end
  end

  // Sweep state, trace count and reported mode.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state            <= ST_RUN;
      reported_mode    <= `TDP_MODE_OVERWRITE;
      traces_collected <= 10'h000;
    end
    else
    begin
      if (!mode_is_frozen)
        reported_mode <= trace_mode_sel;
      case (state)
        ST_RUN:
        begin
          if (mode_is_frozen)
            state <= ST_FROZEN;
          else if (restart)
            traces_collected <= 10'h000;
          else if (take && in_sweep_end)
          begin
            if (traces_collected < depth)
              traces_collected <= traces_collected + 10'h001;
            // One-shot smoothing stops once depth traces are averaged.
            if (one_shot_sweep && reported_mode == `TDP_MODE_SMOOTH &&
                traces_collected + 10'h001 >= depth)
              state <= ST_HALT;
          end
        end
        ST_HALT:
        begin
          if (mode_is_frozen)
            state <= ST_FROZEN;
          else if (restart || !one_shot_sweep)
          begin
            state            <= ST_RUN;
            traces_collected <= 10'h000;
          end
        end
        ST_FROZEN:
        begin
          // Returning to the same retain mode keeps the held trace.
          if (!mode_is_frozen)
          begin
            state <= ST_RUN;
            if (restart)
              traces_collected <= 10'h000;
          end
          else if (setting_change)
            traces_collected <= 10'h000;
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  // Detector selection and coupling to the trace mode.
  wire [2:0] coupled_mode = mode_is_frozen ? reported_mode : trace_mode_sel;

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      active_detector       <= `TDP_DET_BIPOLAR;
      detector_follows_mode <= `TDP_FOLLOW_RESET;
    end
    else if (follows_wr)
    begin
      detector_follows_mode <= follows_value;
      if (follows_value)
        active_detector <= tdp_map_det(coupled_mode);
    end
    else if (detector_manual_wr && (!detector_follows_mode ||
             detector_manual == `TDP_DET_POWER))
    begin
      active_detector <= detector_manual;
      if (detector_manual == `TDP_DET_POWER)
        detector_follows_mode <= 1'b0;
    end
    else if (detector_follows_mode)
      active_detector <= tdp_map_det(coupled_mode);
  end

endmodule

// >>> tb/tdp_core_chk.sv
// Port-level assertions for the trace detector processor.
`timescale 1ns/100ps
module tdp_core_chk
(
  // Clock and reset
  input wire       clk,
  input wire       reset,
  // Stream and settings
  input wire       in_valid,
  input wire       in_pixel_end,
  input wire [2:0] trace_mode_sel,
  input wire [2:0] detector_manual,
  input wire       detector_manual_wr,
  input wire       follows_wr,
  input wire       follows_value,
  // Results and status
  input wire       out_valid,
  input wire [8:0] out_pixel,
  input wire [2:0] active_detector,
  input wire       detector_follows_mode,
  input wire [2:0] reported_mode,
  input wire       view_freeze,
  input wire       measure_abort,
  input wire       sweep_halted
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);

  // While frozen the reported mode is the held one, so the mapping still applies.
  wire [2:0] mapped = (reported_mode == 3'h1) ? 3'h3 : (reported_mode == 3'h2) ? 3'h1 :
                      (reported_mode == 3'h3) ? 3'h2 : 3'h0;

  property p_pix; out_valid |-> out_pixel <= 9'h12C; endproperty
  property p_cause; out_valid |-> $past(in_valid) && $past(in_pixel_end); endproperty
  property p_map; detector_follows_mode |-> active_detector == mapped; endproperty
  property p_on;
    follows_wr && follows_value |=> detector_follows_mode && active_detector == mapped;
  endproperty
  property p_off; follows_wr && !follows_value |=> !detector_follows_mode; endproperty
  property p_unmap;
    !follows_wr && detector_manual_wr && detector_manual == 3'h4
      |=> !detector_follows_mode && active_detector == 3'h4;
  endproperty
  property p_manual;
    !follows_wr && detector_manual_wr && !detector_follows_mode && detector_manual <= 3'h4
      |=> active_detector == $past(detector_manual);
  endproperty
  property p_hold;
    !detector_follows_mode && !detector_manual_wr && !follows_wr |=> $stable(active_detector);
  endproperty
  property p_frozen; view_freeze |-> !out_valid; endproperty
  property p_abort; trace_mode_sel == 3'h4 |=> view_freeze && measure_abort; endproperty
  property p_halt; sweep_halted ##1 sweep_halted |-> !out_valid; endproperty

  a_pix: assert property (p_pix) else $error("pixel index past last");
  a_cause: assert property (p_cause) else $error("result without slice end");
  a_map: assert property (p_map) else $error("coupled detector wrong");
  a_on: assert property (p_on) else $error("coupling not applied");
  a_off: assert property (p_off) else $error("coupling not cleared");
  a_unmap: assert property (p_unmap) else $error("unmapped pick kept coupling");
  a_manual: assert property (p_manual) else $error("manual pick lost");
  a_hold: assert property (p_hold) else $error("manual detector moved");
  a_frozen: assert property (p_frozen) else $error("result while frozen");
  a_abort: assert property (p_abort) else $error("frozen mode not entered");
  a_halt: assert property (p_halt) else $error("result after halt");

  c_freeze: cover property (view_freeze);
  c_unmap: cover property ($fell(detector_follows_mode));
  c_halt: cover property ($rose(sweep_halted));
endmodule

bind tdp_core tdp_core_chk u_chk (.clk, .reset, .in_valid, .in_pixel_end, .trace_mode_sel,
  .detector_manual,
  .detector_manual_wr, .follows_wr, .follows_value, .out_valid, .out_pixel, .active_detector,
  .detector_follows_mode, .reported_mode, .view_freeze, .measure_abort, .sweep_halted);

// >>> tb/tdp_fe_model.sv
// Front end model that streams video samples into the processor.
`timescale 1ns/100ps
module tdp_fe_model
(
  // Clock
  input  wire        clk,
  // Video stream
  output reg         in_valid = 0,
  output reg  [15:0] in_level = 16'h0000,
  output reg         in_pixel_end = 0,
  output reg         in_sweep_end = 0
);
  // One slice of two samples; the idle level is inverted so stale data never passes as valid.
  task pix(input [15:0] a, input [15:0] b, input se);
    @(posedge clk);
    #2;
    in_valid = 1;
    in_level = a;
    @(posedge clk);
    #2;
    in_level = b;
    in_pixel_end = 1;
    in_sweep_end = se;
    @(posedge clk);
    #2;
    in_valid = 0;
    in_pixel_end = 0;
    in_sweep_end = 0;
    in_level = ~b;
  endtask
endmodule

// >>> tb/trace_detector_processor_tb_top.sv
// Testbench for the trace detector processor with a behavioural trace model.
`timescale 1ns/100ps
module trace_detector_processor_tb_top;
  reg         clk = 0;
  reg         reset = 1;
  reg  [2:0]  trace_mode_sel = 3'h0;
  reg  [9:0]  smoothing_depth = 10'h00A;
  reg         one_shot_sweep = 0;
  reg         setting_change = 0;
  reg  [2:0]  detector_manual = 3'h0;
  reg         detector_manual_wr = 0;
  reg         follows_wr = 0;
  reg         follows_value = 0;
  wire        in_valid, in_pixel_end, in_sweep_end, out_valid, view_freeze, measure_abort;
  wire        sweep_halted, detector_follows_mode;
  wire [15:0] in_level, out_hi, out_lo;
  wire [8:0]  out_pixel;
  wire [2:0]  active_detector, reported_mode;
  wire [9:0]  traces_collected;
  int         bad_count = 0, n_checks = 0, n_out = 0;
  int         md = 0, det = 0, fol = 1, cnt = 0, pidx = 0, dep = 10;
  int         hs[301], ls[301], qp[$], qh[$], ql[$];
  int         sv[3] = '{16'h0064, 16'h012C, 16'h01F4};

  always #10 clk = ~clk;

  tdp_core dut (.clk, .reset, .in_valid, .in_level, .in_pixel_end, .in_sweep_end,
    .trace_mode_sel, .smoothing_depth, .one_shot_sweep, .setting_change, .detector_manual,
    .detector_manual_wr, .follows_wr, .follows_value, .out_valid, .out_pixel, .out_hi,
    .out_lo, .active_detector, .detector_follows_mode, .reported_mode, .view_freeze,
    .measure_abort, .sweep_halted, .traces_collected);
  tdp_fe_model fe (.clk, .in_valid, .in_level, .in_pixel_end, .in_sweep_end);

  task tick;
    @(posedge clk);
    #2;
  endtask

  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task end_sim;
    $display("Checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  function int map(input int m);
    return m == 1 ? 3 : m == 2 ? 1 : m == 3 ? 2 : 0;
  endfunction

  function int rnd;
    return $urandom_range(16'hFFFF);
  endfunction

  // The first trace after a restart always replaces the store.
  function int comb(input int o, input int v, input int n);
    if (md == 0 || cnt == 0)
      return v;
    if (md == 1)
      return o + (v - o) / n;
    if (md == 2)
      return v > o ? v : o;
    return v < o ? v : o;
  endfunction

  task mode(input int m);
    tick;
    trace_mode_sel = m[2:0];
    if (m != 4 && m != md)
    begin
      cnt = 0;
      pidx = 0;
      md = m;
    end
    if (fol && m != 4)
      det = map(m);
    tick;
  endtask

  // Kind 0 picks a detector, 1 writes coupling, 2 flags a comparability change.
  task pulse(input int k, input int v);
    tick;
    detector_manual = v[2:0];
    detector_manual_wr = (k == 0);
    follows_wr = (k == 1);
    follows_value = v[0];
    setting_change = (k == 2);
    tick;
    detector_manual_wr = 0;
    follows_wr = 0;
    setting_change = 0;
    fol = (k == 1) ? v : (k == 0 && v == 4) ? 0 : fol;
    det = (k == 1 && fol) ? map(md) : (k == 0 && !fol) ? v : det;
    cnt = (k == 2) ? 0 : cnt;
    pidx = (k == 2) ? 0 : pidx;
  endtask

  task px(input int a, input int b, input bit se, input bit ok);
    int mx, mn, pw, n;
    mx = a > b ? a : b;
    mn = a > b ? b : a;
    pw = $rtoi($sqrt((longint'(a) * a + longint'(b) * b) / 2));
    n = cnt < dep ? cnt + 1 : dep;
    if (ok)
    begin
      hs[pidx] = comb(hs[pidx], det == 2 ? mn : det == 3 ? a : det == 4 ? pw : mx, n);
      ls[pidx] = comb(ls[pidx], det == 1 ? mx : det == 3 ? a : det == 4 ? pw : mn, n);
      qp.push_back(pidx);
      qh.push_back(hs[pidx]);
      ql.push_back(ls[pidx]);
      pidx = se ? 0 : pidx + 1;
      cnt = se && cnt < dep ? cnt + 1 : cnt;
    end
    fe.pix(a[15:0], b[15:0], se);
  endtask

  always @(posedge clk)
  begin
    #1;
    if (out_valid === 1'b1)
    begin
      n_out++;
      if (qp.size() == 0)
        chk("out_valid", 0, 16'(out_valid));
      else
      begin
        chk("out_pixel", 16'(qp.pop_front()), 16'(out_pixel));
        chk("out_hi", 16'(qh.pop_front()), out_hi);
        chk("out_lo", 16'(ql.pop_front()), out_lo);
      end
    end
  end

  initial
  begin
    #400000;
    bad_count++;
    end_sim;
  end

  initial
  begin
    void'($urandom(49));
    repeat (6) @(posedge clk);
    #2;
    reset = 0;
    chk("mode", 0, 16'(reported_mode));
    chk("det", 0, 16'(active_detector));
    chk("follow", 1, 16'(detector_follows_mode));
    for (int m = 3; m >= 0; m--)
    begin
      mode(m);
      chk("det", 16'(det), 16'(active_detector));
    end
    pulse(1, 0);
    mode(2);
    chk("det", 16'(det), 16'(active_detector));
    pulse(1, 1);
    chk("det", 16'(det), 16'(active_detector));
    pulse(0, 1);
    pulse(0, 4);
    chk("follow", 0, 16'(detector_follows_mode));
    chk("det", 16'(det), 16'(active_detector));
    mode(0);
    for (int d = 0; d < 5; d++)
    begin
      pulse(0, d);
      px(rnd(), rnd(), 1, 1);
    end
    pulse(0, 0);
    n_out = 0;
    for (int p = 0; p < 301; p++)
      px(rnd(), rnd(), p == 300, 1);
    chk("pixels", 16'h012D, 16'(n_out));
    smoothing_depth = 10'h002;
    dep = 2;
    mode(1);
    pulse(0, 1);
    foreach (sv[i])
      px(sv[i], sv[i], 1, 1);
    chk("traces", 2, 16'(traces_collected));
    one_shot_sweep = 1;
    pulse(2, 0);
    px(16'h0190, 16'h0190, 1, 1);
    px(16'h00C8, 16'h00C8, 1, 1);
    chk("halted", 1, 16'(sweep_halted));
    px(rnd(), rnd(), 1, 0);
    one_shot_sweep = 0;
    for (int m = 2; m < 4; m++)
    begin
      mode(m);
      for (int i = 0; i < 6; i++)
      begin
        if (i == 3)
          pulse(2, 0);
        px(rnd(), rnd(), 1, 1);
      end
    end
    mode(4);
    chk("freeze", 1, 16'(view_freeze));
    chk("abort", 1, 16'(measure_abort));
    chk("mode", 3, 16'(reported_mode));
    px(rnd(), rnd(), 1, 0);
    mode(3);
    px(rnd(), rnd(), 1, 1);
    tick;
    chk("pending", 0, 16'(qp.size()));
    end_sim;
  end
endmodule
